// ===== hdl/bridge_gc_cfg.svh
// Offsets, field positions, reset values and codes of the control fields
`ifndef BRIDGE_GC_CFG_SVH
`define BRIDGE_GC_CFG_SVH

// Configuration space location of the register
`define GC_OFFSET 8'hd4
// Reset value of the whole register; other fields read as these defaults
`define GC_RESET_VALUE 32'h8600025f

// Field positions
`define GC_RESP_SEL_HI 22
`define GC_RESP_SEL_LO 20
`define GC_PREFETCH_OFF_BIT 19
`define GC_STANDBY_LAT_HI 18
`define GC_STANDBY_LAT_LO 16
`define GC_LOWPOWER_LAT_HI 15
`define GC_LOWPOWER_LAT_LO 13
`define GC_VC_STRUCT_BIT 12
`define GC_SLEEP_CLK_BIT 11
`define GC_BEACON_BIT 10
// Mask of the bits this block owns, 22 down to 10
`define GC_OWNED_MASK 32'h007ffc00

// Field reset values
`define GC_RESP_SEL_RST 3'h0
`define GC_LAT_RST 3'h0
`define GC_BIT_RST 1'h0
`define GC_VC_STRUCT_VAL 1'h0

// Slot power response codes
`define RESP_IGNORE 3'h0
`define RESP_ALERT 3'h1
`define RESP_CLK_STOP 3'h2
`define RESP_CLK_STOP_ALERT 3'h3
`define RESP_UR_ALL 3'h4

// Secondary clock outputs
`define SEC_CLK_COUNT 7

`endif

// ===== hdl/bridge_gc_pkg.sv
// Types shared by the bridge general control fields
package bridge_gc_pkg;

  // Stored fields; the last two are sticky
  typedef struct packed {
    logic [2:0] slot_power_response_sel;
    logic plain_read_prefetch_off;
    logic [2:0] standby_exit_latency_cfg;
    logic [2:0] lowpower_exit_latency_cfg;
    logic sleep_clock_stop_en;
    logic beacon_en;
  } gc_fields_s;

  // Configuration write or read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

endpackage

// ===== hdl/bridge_general_control_fields.sv
// Bridge general control register, fields 22 down to 10
// Functional notes
// - Response code in bits 22:20 acts only while slot power is insufficient.
// - Code 000 ignores the slot power limit; bridge runs normally.
// - Code 001 drives the power limit alert pin while power is short.
// - Code 010 stops masked secondary clocks, alert pin stays inactive.
// - Code 011 stops masked secondary clocks and drives the alert pin.
// - Code 100 rejects all but configuration and slot power limit traffic.
// - Prefetch-off clear: all three memory read kinds are prefetchable.
// - Prefetch-off set: plain memory read not prefetched; line and multiple are.
// - Standby exit latency bits 18:16 mirror into capability bits 8:6.
// - Standby latency codes: 000 under 64 ns, doubling, 111 over 4 us.
// - Low power exit latency bits 15:13 mirror into capability bits 11:9.
// - Low power latency codes: 000 under 1 us, doubling, 111 over 64 us.
// - Virtual channel structure enable bit 12 is read-only zero.
// - Sleep clock stop set: secondary clocks stop in D3; clear keeps them.
// - Beacon clear: wake signal only; set: beacon and wake signal both.
// - Sleep clock stop and beacon bits are sticky across link resets.
// - Other fields reset on link reset, global reset or power-on reset.
// - Register sits at offset D4h, default 8600025Fh, owned fields zero.
// - Clock mask acts only for codes 010 or 011 with power short.
`timescale 1ns/1ns
`include "bridge_gc_cfg.svh"

module bridge_general_control_fields #(
  parameter int CLK_N = `SEC_CLK_COUNT
) (
  // Clock and power-on reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Other reset sources
  input wire logic i_link_reset,
  input wire logic i_global_reset_n,
  // Configuration access
  input wire bridge_gc_pkg::cfg_req_s i_cfg,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rdata_valid,
  // Power and clock status
  input wire logic i_slot_power_short,
  input wire logic i_in_d3,
  input wire logic [CLK_N-1:0] i_clock_mask,
  // Controls to the bridge
  output logic o_power_limit_alert_pin,
  output logic [CLK_N-1:0] o_sec_clk_stop,
  output logic o_ur_noncfg,
  output logic o_plain_read_prefetch_ok,
  output logic [2:0] o_cap_standby_exit_latency,
  output logic [2:0] o_cap_lowpower_exit_latency,
  output logic o_beacon_wake_en,
  output logic o_wake_signal_en
);

  bridge_gc_pkg::gc_fields_s fields;
  logic global_reset_n_meta;
  logic global_reset_n_sync_n;
  logic soft_reset;
  logic gc_wr;
  logic [31:0] rd_word;
  logic want_alert;
  logic want_clk_mask;
  logic want_ur;
  logic [2:0] actions;

  // Decoded response actions
  function automatic logic [2:0] resp_actions(input logic [2:0] sel);
    begin
      case (sel)
        `RESP_ALERT: resp_actions = 3'h1;
        `RESP_CLK_STOP: resp_actions = 3'h2;
        `RESP_CLK_STOP_ALERT: resp_actions = 3'h3;
        `RESP_UR_ALL: resp_actions = 3'h4;
        default: resp_actions = 3'h0;
      endcase
    end
  endfunction

  // Global reset pin synchroniser
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      global_reset_n_meta <= 1'h0;
      global_reset_n_sync_n <= 1'h0;
    end else begin
      global_reset_n_meta <= i_global_reset_n;
      global_reset_n_sync_n <= global_reset_n_meta;
    end
  end

  assign soft_reset = i_link_reset | ~global_reset_n_sync_n;
  assign gc_wr = i_cfg.wr && (i_cfg.addr == `GC_OFFSET);

  // Field storage; the sticky pair survives link and global reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fields.slot_power_response_sel <= `GC_RESP_SEL_RST;
      fields.plain_read_prefetch_off <= `GC_BIT_RST;
      fields.standby_exit_latency_cfg <= `GC_LAT_RST;
      fields.lowpower_exit_latency_cfg <= `GC_LAT_RST;
      fields.sleep_clock_stop_en <= `GC_BIT_RST;
      fields.beacon_en <= `GC_BIT_RST;
    end else begin
      if (soft_reset) begin
        fields.slot_power_response_sel <= `GC_RESP_SEL_RST;
        fields.plain_read_prefetch_off <= `GC_BIT_RST;
        fields.standby_exit_latency_cfg <= `GC_LAT_RST;
        fields.lowpower_exit_latency_cfg <= `GC_LAT_RST;
      end else if (gc_wr) begin
        if (i_cfg.be[2]) begin
          fields.slot_power_response_sel <=
            i_cfg.wdata[`GC_RESP_SEL_HI:`GC_RESP_SEL_LO];
          fields.plain_read_prefetch_off <=
            i_cfg.wdata[`GC_PREFETCH_OFF_BIT];
          fields.standby_exit_latency_cfg <=
            i_cfg.wdata[`GC_STANDBY_LAT_HI:`GC_STANDBY_LAT_LO];
        end
        if (i_cfg.be[1]) begin
          fields.lowpower_exit_latency_cfg <=
            i_cfg.wdata[`GC_LOWPOWER_LAT_HI:`GC_LOWPOWER_LAT_LO];
        end
      end
      if (gc_wr && i_cfg.be[1]) begin
        fields.sleep_clock_stop_en <= i_cfg.wdata[`GC_SLEEP_CLK_BIT];
        fields.beacon_en <= i_cfg.wdata[`GC_BEACON_BIT];
      end
    end
  end

  // Read word: owned fields over the defaults of the rest
  always_comb begin
    rd_word = `GC_RESET_VALUE & ~`GC_OWNED_MASK;
    rd_word[`GC_RESP_SEL_HI:`GC_RESP_SEL_LO] = fields.slot_power_response_sel;
    rd_word[`GC_PREFETCH_OFF_BIT] = fields.plain_read_prefetch_off;
    rd_word[`GC_STANDBY_LAT_HI:`GC_STANDBY_LAT_LO] =
      fields.standby_exit_latency_cfg;
    rd_word[`GC_LOWPOWER_LAT_HI:`GC_LOWPOWER_LAT_LO] =
      fields.lowpower_exit_latency_cfg;
    rd_word[`GC_VC_STRUCT_BIT] = `GC_VC_STRUCT_VAL;
    rd_word[`GC_SLEEP_CLK_BIT] = fields.sleep_clock_stop_en;
    rd_word[`GC_BEACON_BIT] = fields.beacon_en;
  end

  // Read answer one cycle after the request; other offsets read zero
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= 32'h0;
      o_cfg_rdata_valid <= 1'h0;
    end else begin
      o_cfg_rdata_valid <= i_cfg.rd;
      if (i_cfg.rd) begin
        o_cfg_rdata <= (i_cfg.addr == `GC_OFFSET) ? rd_word : 32'h0;
      end
    end
  end

  // Slot power response
  always_comb begin
    actions = resp_actions(fields.slot_power_response_sel);
    want_alert = i_slot_power_short && actions[0];
    want_clk_mask = i_slot_power_short && actions[1];
    want_ur = i_slot_power_short && actions[2];
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_power_limit_alert_pin <= 1'h0;
      o_ur_noncfg <= 1'h0;
    end else begin
      o_power_limit_alert_pin <= want_alert;
      o_ur_noncfg <= want_ur;
    end
  end

  // Secondary clock stop: override mask or D3 stop
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_sec_clk_stop <= '0;
    end else if (fields.sleep_clock_stop_en && i_in_d3) begin
      o_sec_clk_stop <= '1;
    end else begin
      o_sec_clk_stop <= want_clk_mask ? i_clock_mask : '0;
    end
  end

  // Prefetch, capability mirror and wake method
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_plain_read_prefetch_ok <= 1'h1;
      o_cap_standby_exit_latency <= `GC_LAT_RST;
      o_cap_lowpower_exit_latency <= `GC_LAT_RST;
      o_beacon_wake_en <= 1'h0;
      o_wake_signal_en <= 1'h1;
    end else begin
      o_plain_read_prefetch_ok <= ~fields.plain_read_prefetch_off;
      o_cap_standby_exit_latency <= fields.standby_exit_latency_cfg;
      o_cap_lowpower_exit_latency <=
        fields.lowpower_exit_latency_cfg;
      o_beacon_wake_en <= fields.beacon_en;
      o_wake_signal_en <= 1'h1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_NO_SHORT_NO_ACTION:
  assert property (!i_slot_power_short |=> !o_power_limit_alert_pin &&
    !o_ur_noncfg) else $error("override action without power shortage");

  AST_IGNORE_CODE:
  assert property (fields.slot_power_response_sel == `RESP_IGNORE |=>
    !o_power_limit_alert_pin && !o_ur_noncfg)
    else $error("code 000 produced an action");

  AST_ALERT_CODE:
  assert property (i_slot_power_short &&
    fields.slot_power_response_sel == `RESP_ALERT |=>
    o_power_limit_alert_pin) else $error("alert pin not driven");

  AST_CLK_STOP_NO_ALERT:
  assert property (fields.slot_power_response_sel == `RESP_CLK_STOP &&
    !(fields.sleep_clock_stop_en && i_in_d3) |=>
    !o_power_limit_alert_pin && o_sec_clk_stop ==
    ($past(i_slot_power_short) ? $past(i_clock_mask) : '0))
    else $error("code 010 wrong response");

  AST_CLK_STOP_ALERT:
  assert property (i_slot_power_short &&
    fields.slot_power_response_sel == `RESP_CLK_STOP_ALERT &&
    !i_in_d3 |=> o_power_limit_alert_pin &&
    o_sec_clk_stop == $past(i_clock_mask))
    else $error("code 011 wrong response");

  AST_UR_CODE:
  assert property (i_slot_power_short &&
    fields.slot_power_response_sel == `RESP_UR_ALL |=>
    o_ur_noncfg && !o_power_limit_alert_pin)
    else $error("code 100 did not reject traffic");

  AST_PREFETCH:
  assert property (gc_wr && !soft_reset && i_cfg.be[2] |=> ##1
    o_plain_read_prefetch_ok == !$past(i_cfg.wdata[19], 2))
    else $error("prefetch control not applied");

  AST_STANDBY_MIRROR:
  assert property (##1 o_cap_standby_exit_latency ==
    $past(fields.standby_exit_latency_cfg))
    else $error("standby latency not mirrored");

  AST_LOWPOWER_MIRROR:
  assert property (##1 o_cap_lowpower_exit_latency ==
    $past(fields.lowpower_exit_latency_cfg))
    else $error("low power latency not mirrored");

  AST_VC_ZERO:
  assert property (o_cfg_rdata_valid |-> !o_cfg_rdata[`GC_VC_STRUCT_BIT])
    else $error("virtual channel bit read as one");

  AST_D3_STOP:
  assert property (fields.sleep_clock_stop_en && i_in_d3 |=>
    &o_sec_clk_stop) else $error("clocks not stopped in D3");

  AST_STICKY:
  assert property (i_link_reset && !gc_wr |=>
    $stable(fields.sleep_clock_stop_en) && $stable(fields.beacon_en))
    else $error("sticky bit lost on link reset");

  AST_LINK_RESET:
  assert property (i_link_reset |=> fields.slot_power_response_sel == 3'h0 &&
    !fields.plain_read_prefetch_off &&
    fields.standby_exit_latency_cfg == 3'h0 &&
    fields.lowpower_exit_latency_cfg == 3'h0)
    else $error("field survived link reset");

  AST_RESERVED:
  assert property (fields.slot_power_response_sel > `RESP_UR_ALL &&
    !i_in_d3 |=> !o_power_limit_alert_pin && !o_ur_noncfg &&
    o_sec_clk_stop == '0) else $error("reserved code acted");

  AST_SEL_WRITE:
  assert property (gc_wr && !soft_reset && i_cfg.be[2] |=>
    fields.slot_power_response_sel ==
    $past(i_cfg.wdata[`GC_RESP_SEL_HI:`GC_RESP_SEL_LO]))
    else $error("response code write lost");

  AST_STANDBY_WRITE:
  assert property (gc_wr && !soft_reset && i_cfg.be[2] |=>
    fields.standby_exit_latency_cfg ==
    $past(i_cfg.wdata[`GC_STANDBY_LAT_HI:`GC_STANDBY_LAT_LO]))
    else $error("standby latency write lost");

  AST_LOWPOWER_WRITE:
  assert property (gc_wr && !soft_reset && i_cfg.be[1] |=>
    fields.lowpower_exit_latency_cfg ==
    $past(i_cfg.wdata[`GC_LOWPOWER_LAT_HI:`GC_LOWPOWER_LAT_LO]))
    else $error("low power latency write lost");

  AST_STICKY_WRITE:
  assert property (gc_wr && i_cfg.be[1] |=>
    fields.sleep_clock_stop_en == $past(i_cfg.wdata[`GC_SLEEP_CLK_BIT]) &&
    fields.beacon_en == $past(i_cfg.wdata[`GC_BEACON_BIT]))
    else $error("sticky bit write lost");

  AST_GLOBAL_RESET:
  assert property (!global_reset_n_sync_n |=> fields.slot_power_response_sel == 3'h0 &&
    !fields.plain_read_prefetch_off &&
    fields.standby_exit_latency_cfg == 3'h0 &&
    fields.lowpower_exit_latency_cfg == 3'h0)
    else $error("field survived global reset");

  AST_READ_VALID:
  assert property (o_cfg_rdata_valid == $past(i_cfg.rd))
    else $error("read valid not one cycle after request");

  AST_READ_OTHER:
  assert property (i_cfg.rd && i_cfg.addr != `GC_OFFSET |=>
    o_cfg_rdata == 32'h0) else $error("other offset read not zero");

  AST_READ_FIXED:
  assert property (i_cfg.rd && i_cfg.addr == `GC_OFFSET |=>
    (o_cfg_rdata & ~`GC_OWNED_MASK) ==
    (`GC_RESET_VALUE & ~`GC_OWNED_MASK))
    else $error("unowned bits differ from default");

  AST_WAKE_METHOD:
  assert property (##1 o_wake_signal_en &&
    o_beacon_wake_en == $past(fields.beacon_en))
    else $error("wake method wrong");

  AST_PREFETCH_CLEAR:
  assert property (!fields.plain_read_prefetch_off |=>
    o_plain_read_prefetch_ok) else $error("plain read not prefetchable");

  AST_CLOCKS_RUN:
  assert property (!fields.sleep_clock_stop_en && !want_clk_mask |=>
    o_sec_clk_stop == '0) else $error("secondary clock stopped");

  AST_ALERT_CLOCKS_RUN:
  assert property (fields.slot_power_response_sel == `RESP_ALERT &&
    !(fields.sleep_clock_stop_en && i_in_d3) |=> o_sec_clk_stop == '0)
    else $error("code 001 stopped a clock");

  AST_MASK_NEEDS_SHORT:
  assert property (!i_slot_power_short &&
    !(fields.sleep_clock_stop_en && i_in_d3) |=> o_sec_clk_stop == '0)
    else $error("clock masked without power shortage");

endmodule

// ===== test/bridge_general_control_fields_test.sv
// Self-checking bench for the bridge general control fields
`timescale 1ns/1ns
`include "bridge_gc_cfg.svh"

module bridge_general_control_fields_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_link_reset = 1'b0;
  logic i_global_reset_n = 1'b1;
  bridge_gc_pkg::cfg_req_s i_cfg = '0;
  logic i_slot_power_short = 1'b0;
  logic i_in_d3 = 1'b0;
  logic [6:0] i_clock_mask = 7'h00;
  logic [31:0] o_cfg_rdata;
  logic o_cfg_rdata_valid;
  logic o_power_limit_alert_pin;
  logic [6:0] o_sec_clk_stop;
  logic o_ur_noncfg;
  logic o_plain_read_prefetch_ok;
  logic [2:0] o_cap_standby_exit_latency;
  logic [2:0] o_cap_lowpower_exit_latency;
  logic o_beacon_wake_en;
  logic o_wake_signal_en;
  bridge_gc_pkg::gc_fields_s mdl = '0;
  logic [31:0] lfsr = 32'h00000054;
  logic [31:0] d;
  int fails = 0;
  int checks = 0;

  always #4 i_mclk = ~i_mclk;

  bridge_general_control_fields #(.CLK_N(7)) i_bridge_general_control_fields (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_link_reset(i_link_reset),
    .i_global_reset_n(i_global_reset_n), .i_cfg(i_cfg),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_rdata_valid(o_cfg_rdata_valid),
    .i_slot_power_short(i_slot_power_short), .i_in_d3(i_in_d3),
    .i_clock_mask(i_clock_mask),
    .o_power_limit_alert_pin(o_power_limit_alert_pin),
    .o_sec_clk_stop(o_sec_clk_stop), .o_ur_noncfg(o_ur_noncfg),
    .o_plain_read_prefetch_ok(o_plain_read_prefetch_ok),
    .o_cap_standby_exit_latency(o_cap_standby_exit_latency),
    .o_cap_lowpower_exit_latency(o_cap_lowpower_exit_latency),
    .o_beacon_wake_en(o_beacon_wake_en),
    .o_wake_signal_en(o_wake_signal_en));

  function automatic logic [31:0] rnd_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] exp_rd();
    logic [31:0] v;
    v = `GC_RESET_VALUE & ~`GC_OWNED_MASK;
    v[22:20] = mdl.slot_power_response_sel;
    v[19] = mdl.plain_read_prefetch_off;
    v[18:16] = mdl.standby_exit_latency_cfg;
    v[15:13] = mdl.lowpower_exit_latency_cfg;
    v[12] = `GC_VC_STRUCT_VAL;
    v[11] = mdl.sleep_clock_stop_en;
    v[10] = mdl.beacon_en;
    return v;
  endfunction

  function automatic logic [6:0] exp_stop();
    logic [2:0] c;
    c = mdl.slot_power_response_sel;
    if (i_in_d3 && mdl.sleep_clock_stop_en)
      return 7'h7f;
    if (i_slot_power_short && (c == `RESP_CLK_STOP ||
        c == `RESP_CLK_STOP_ALERT))
      return i_clock_mask;
    return 7'h00;
  endfunction

  task automatic wrap_up();
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_out();
    logic [2:0] c;
    logic s;
    c = mdl.slot_power_response_sel;
    s = i_slot_power_short;
    chk(o_cap_standby_exit_latency, mdl.standby_exit_latency_cfg);
    chk(o_cap_lowpower_exit_latency, mdl.lowpower_exit_latency_cfg);
    chk(o_plain_read_prefetch_ok, !mdl.plain_read_prefetch_off);
    chk(o_beacon_wake_en, mdl.beacon_en);
    chk(o_wake_signal_en, 1'b1);
    chk(o_power_limit_alert_pin, s && c[0] && c < 3'h4);
    chk(o_sec_clk_stop, exp_stop());
    chk(o_ur_noncfg, s && c == `RESP_UR_ALL);
    chk(o_cfg_rdata_valid, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] v);
    @(posedge i_mclk);
    i_cfg <= '{1'b1, 1'b0, a, be, v};
    @(posedge i_mclk);
    i_cfg <= '0;
    if (a == `GC_OFFSET && be[2])
      {mdl.slot_power_response_sel, mdl.plain_read_prefetch_off,
       mdl.standby_exit_latency_cfg} = v[22:16];
    if (a == `GC_OFFSET && be[1]) begin
      mdl.lowpower_exit_latency_cfg = v[15:13];
      mdl.sleep_clock_stop_en = v[11];
      mdl.beacon_en = v[10];
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_cfg <= '{1'b0, 1'b1, a, 4'hf, 32'h00000000};
    @(posedge i_mclk);
    i_cfg <= '0;
    #1;
    chk(o_cfg_rdata_valid, 1'b1);
    chk(o_cfg_rdata, exp);
  endtask

  task automatic setenv(input logic s, input logic d3, input logic [6:0] m);
    @(posedge i_mclk);
    i_slot_power_short <= s;
    i_in_d3 <= d3;
    i_clock_mask <= m;
    @(posedge i_mclk);
    #1;
    chk_out();
  endtask

  task automatic clr_soft();
    mdl = '{3'h0, 1'b0, 3'h0, 3'h0, mdl.sleep_clock_stop_en, mdl.beacon_en};
  endtask

  initial begin
    #500000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    chk_out();
    rd(`GC_OFFSET, `GC_RESET_VALUE);
    // Every response code, with power short and then sufficient
    for (int c = 0; c < 8; c++) begin
      wr(`GC_OFFSET, 4'h4, 32'(c) << 20);
      setenv(1'b1, 1'b0, 7'h55);
      rd(`GC_OFFSET, exp_rd());
      setenv(1'b0, 1'b0, 7'h2a);
    end
    // Clock stop in D3, with the mask also active
    wr(`GC_OFFSET, 4'h6, 32'h00300800);
    setenv(1'b1, 1'b1, 7'h01);
    wr(`GC_OFFSET, 4'h2, 32'h00000000);
    setenv(1'b1, 1'b1, 7'h01);
    // Other addresses are ignored and read as zero
    wr(8'hd8, 4'hf, 32'hffffffff);
    rd(8'hd8, 32'h00000000);
    rd(`GC_OFFSET, exp_rd());
    repeat (60) begin
      lfsr = rnd_next(lfsr);
      d = lfsr;
      lfsr = rnd_next(lfsr);
      wr(`GC_OFFSET, lfsr[3:0], d);
      lfsr = rnd_next(lfsr);
      setenv(lfsr[0], lfsr[1], lfsr[8:2]);
      rd(`GC_OFFSET, exp_rd());
    end
    // Link reset keeps the sticky bits
    wr(`GC_OFFSET, 4'h6, `GC_OWNED_MASK);
    @(posedge i_mclk);
    i_link_reset <= 1'b1;
    @(posedge i_mclk);
    i_link_reset <= 1'b0;
    clr_soft();
    setenv(1'b1, 1'b1, 7'h7f);
    rd(`GC_OFFSET, exp_rd());
    // Global reset keeps the sticky bits
    wr(`GC_OFFSET, 4'h6, `GC_OWNED_MASK);
    @(posedge i_mclk);
    i_global_reset_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_global_reset_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    clr_soft();
    setenv(1'b1, 1'b0, 7'h33);
    rd(`GC_OFFSET, exp_rd());
    // Power-on reset in mid-run clears everything
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    mdl = '0;
    setenv(1'b0, 1'b1, 7'h00);
    rd(`GC_OFFSET, `GC_RESET_VALUE);
    wrap_up();
  end
endmodule
